// file: core/cls_defs.svh
// Purpose: encoding constants of the compressed load/store expander
// Assumes: 16-bit compressed input, 32-bit base encodings out
// Notes:   definitions only
`ifndef CLS_DEFS_SVH
`define CLS_DEFS_SVH
// ==========================================
// compressed side
// ==========================================
`define Q_MEM       2'h0  // quadrant of register-based forms
`define Q_STK       2'h2  // quadrant of stack-relative stores
`define F3_FLD_LQ   3'h1
`define F3_LW       3'h2
`define F3_FLW_LD   3'h3
`define F3_FSD_SQ   3'h5
`define F3_SW       3'h6
`define F3_FSW_SD   3'h7
`define REG_SP      5'h02 // stack pointer x2
`define CREG_HI     2'h1  // 3-bit field maps to 8..15
// ==========================================
// expanded side
// ==========================================
`define OPC_LOAD    7'h03
`define OPC_LOADFP  7'h07
`define OPC_MISCMEM 7'h0F // quad load lives here
`define OPC_STORE   7'h23
`define OPC_STOREFP 7'h27
`define W3_WORD     3'h2
`define W3_DWORD    3'h3
`define W3_QWORD    3'h4
`define INSTR_ZERO  32'h0000_0000
`endif

// file: core/cls_expander.sv
// Purpose: expand compressed loads/stores to base encodings
// Assumes: config inputs come from logic on ref_clk
// Notes:   one-stage pipe with valid/ready on both sides
// Contract
// - stack dword store, 64/128 base, x8 scale
// - stack qword store, 128 base, x16 scale
// - stack float store, 32 base with F
// - stack double store, 32/64 base with D
// - register loads use CL field layout
// - register stores use CS field layout
// - word load, base plus offset times four
// - dword load on 64/128 bases, times eight
// - qword load on 128 base, times sixteen
// - float load on 32 base with F
// - double load on 32/64 with D
// - word store, base plus offset times four
// - dword store on 64/128, times eight
// - qword store on 128 base, times sixteen
// - float store on 32 base with F
// - double store on 32/64 with D
// - 3-bit fields map to registers 8..15
`timescale 1ns/100ps
`default_nettype none
`include "cls_defs.svh"
module cls_expander
   import cls_pkg::*;
(
   input  wire logic        ref_clk,      // core clock
   input  wire logic        rst,          // async, high
   input  wire xlen_t       xlen,         // base width
   input  wire logic        fp_single_en, // F present
   input  wire logic        fp_double_en, // D present
   input  wire logic        in_valid,     // fetch offers
   output logic             in_ready,     // we accept
   input  wire logic [15:0] in_instr,     // compressed
   output logic             out_valid,    // result held
   input  wire logic        out_ready,    // execute takes
   output logic [31:0]      out_instr,    // expanded
   output logic             out_match,    // ours, legal
   output logic             out_illegal,  // ours, not here
   output op_t              out_op,       // operation
   output logic [4:0]       out_base,     // base reg
   output logic [4:0]       out_data,     // data reg
   output logic [11:0]      out_offset    // byte offset
);
   // ==========================================
   // declarations
   // ==========================================
   cls_field_if fld ();          // link to field decoder
   op_t         op;              // decoded operation
   logic        slot;            // opcode slot is ours
   logic        is_css;          // stack-relative form
   scale_t      scale;           // access scale
   logic [31:0] exp_w;           // expanded word
   logic        in_fire;         // accepted this cycle
   logic        out_valid_q;
   logic [31:0] out_instr_q;
   logic        out_match_q;
   logic        out_illegal_q;
   op_t         out_op_q;
   logic [4:0]  out_base_q;
   logic [4:0]  out_data_q;
   logic [11:0] out_offset_q;

   // ==========================================
   // operation select
   // ==========================================
   // config-dependent slots: same bits, other op
   always_comb begin
      op   = OP_NONE;
      slot = 1'b0;
      case (in_instr[1:0])
         `Q_MEM: begin
            case (in_instr[15:13])
               `F3_LW: begin
                  slot = 1'b1;
                  op   = OP_LW;
               end
               `F3_SW: begin
                  slot = 1'b1;
                  op   = OP_SW;
               end
               `F3_FLD_LQ: begin
                  slot = 1'b1;
                  if (xlen == XL_128)
                     op = OP_LQ;
                  else if (fp_double_en)
                     op = OP_FLD;
               end
               `F3_FLW_LD: begin
                  slot = 1'b1;
                  if (xlen != XL_32)
                     op = OP_LD;
                  else if (fp_single_en)
                     op = OP_FLW;
               end
               `F3_FSD_SQ: begin
                  slot = 1'b1;
                  if (xlen == XL_128)
                     op = OP_SQ;
                  else if (fp_double_en)
                     op = OP_FSD;
               end
               `F3_FSW_SD: begin
                  slot = 1'b1;
                  if (xlen != XL_32)
                     op = OP_SD;
                  else if (fp_single_en)
                     op = OP_FSW;
               end
               default: begin
                  op   = OP_NONE;   // other quadrant-0 forms
                  slot = 1'b0;
               end
            endcase
         end
         `Q_STK: begin
            case (in_instr[15:13])
               `F3_FSD_SQ: begin
                  slot = 1'b1;
                  if (xlen == XL_128)
                     op = OP_SQ;
                  else if (fp_double_en)
                     op = OP_FSD;
               end
               `F3_FSW_SD: begin
                  slot = 1'b1;
                  if (xlen != XL_32)
                     op = OP_SD;
                  else if (fp_single_en)
                     op = OP_FSW;
               end
               default: begin
                  op   = OP_NONE;   // stack loads, word store
                  slot = 1'b0;
               end
            endcase
         end
         default: begin
            op   = OP_NONE;         // not a memory quadrant
            slot = 1'b0;
         end
      endcase
   end

   // stack forms only come from quadrant two
   assign is_css = (in_instr[1:0] == `Q_STK);

   // scale follows the data size of the op
   always_comb begin
      case (op)
         OP_LW, OP_SW, OP_FLW, OP_FSW: scale = SC_W;
         OP_LQ, OP_SQ:                 scale = SC_Q;
         default:                      scale = SC_D;
      endcase
   end

   // ==========================================
   // field extraction
   // ==========================================
   assign fld.instr  = in_instr;
   assign fld.is_css = is_css;
   assign fld.scale  = scale;

   cls_field_decode cls_field_decode_i (
      .f (fld.dec)
   );

   // ==========================================
   // base encoding build
   // ==========================================
   // loads are I-type, stores S-type
   always_comb begin
      case (op)
         OP_LW:  exp_w = {fld.offset, fld.base_reg, `W3_WORD,
                          fld.data_reg, `OPC_LOAD};
         OP_LD:  exp_w = {fld.offset, fld.base_reg, `W3_DWORD,
                          fld.data_reg, `OPC_LOAD};
         OP_LQ:  exp_w = {fld.offset, fld.base_reg, `W3_WORD,
                          fld.data_reg, `OPC_MISCMEM};
         OP_FLW: exp_w = {fld.offset, fld.base_reg, `W3_WORD,
                          fld.data_reg, `OPC_LOADFP};
         OP_FLD: exp_w = {fld.offset, fld.base_reg, `W3_DWORD,
                          fld.data_reg, `OPC_LOADFP};
         OP_SW:  exp_w = {fld.offset[11:5], fld.data_reg,
                          fld.base_reg, `W3_WORD,
                          fld.offset[4:0], `OPC_STORE};
         OP_SD:  exp_w = {fld.offset[11:5], fld.data_reg,
                          fld.base_reg, `W3_DWORD,
                          fld.offset[4:0], `OPC_STORE};
         OP_SQ:  exp_w = {fld.offset[11:5], fld.data_reg,
                          fld.base_reg, `W3_QWORD,
                          fld.offset[4:0], `OPC_STORE};
         OP_FSW: exp_w = {fld.offset[11:5], fld.data_reg,
                          fld.base_reg, `W3_WORD,
                          fld.offset[4:0], `OPC_STOREFP};
         OP_FSD: exp_w = {fld.offset[11:5], fld.data_reg,
                          fld.base_reg, `W3_DWORD,
                          fld.offset[4:0], `OPC_STOREFP};
         default: exp_w = `INSTR_ZERO;
      endcase
   end

   // ==========================================
   // handshake
   // ==========================================
   // a held result blocks new input until taken
   assign in_ready = !out_valid_q || out_ready;
   assign in_fire  = in_valid && in_ready;

   // output valid flag
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst)
         out_valid_q <= 1'b0;
      else if (in_ready)
         out_valid_q <= in_valid;
   end

   // result register, loads only on accept
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         out_instr_q   <= `INSTR_ZERO;
         out_match_q   <= 1'b0;
         out_illegal_q <= 1'b0;
         out_op_q      <= OP_NONE;
         out_base_q    <= 5'h00;
         out_data_q    <= 5'h00;
         out_offset_q  <= 12'h000;
      end else if (in_fire) begin
         out_instr_q   <= exp_w;
         out_match_q   <= (op != OP_NONE);
         out_illegal_q <= slot && (op == OP_NONE);
         out_op_q      <= op;
         out_base_q    <= fld.base_reg;
         out_data_q    <= fld.data_reg;
         out_offset_q  <= fld.offset;
      end
   end

   assign out_valid   = out_valid_q;
   assign out_instr   = out_instr_q;
   assign out_match   = out_match_q;
   assign out_illegal = out_illegal_q;
   assign out_op      = out_op_q;
   assign out_base    = out_base_q;
   assign out_data    = out_data_q;
   assign out_offset  = out_offset_q;

   // ==========================================
   // assertions
   // ==========================================
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence s_take(logic [1:0] q, logic [2:0] f3);
      in_fire && in_instr[1:0] == q && in_instr[15:13] == f3;
   endsequence

   sequence s_out(op_t o);
      out_valid && out_match && out_op == o;
   endsequence

   AST_STK_DWORD: assert property (
      s_take(`Q_STK, `F3_FSW_SD) ##0 (xlen != XL_32)
      |=> s_out(OP_SD) ##0 out_base == `REG_SP
          && out_offset[2:0] == 3'h0
          && out_data == $past(in_instr[6:2]))
      else $error("stack dword store misexpanded");

   AST_STK_QWORD: assert property (
      s_take(`Q_STK, `F3_FSD_SQ) ##0 (xlen == XL_128)
      |=> s_out(OP_SQ) ##0 out_offset[3:0] == 4'h0
          && out_instr[14:12] == `W3_QWORD)
      else $error("stack qword store misexpanded");

   AST_STK_FLOAT: assert property (
      s_take(`Q_STK, `F3_FSW_SD) ##0 (xlen == XL_32)
      ##0 fp_single_en
      |=> s_out(OP_FSW) ##0 out_instr[6:0] == `OPC_STOREFP)
      else $error("stack float store misexpanded");

   AST_STK_DOUBLE: assert property (
      s_take(`Q_STK, `F3_FSD_SQ) ##0 (xlen != XL_128)
      ##0 fp_double_en
      |=> s_out(OP_FSD) ##0 out_base == `REG_SP)
      else $error("stack double store misexpanded");

   AST_REG_WORD: assert property (
      s_take(`Q_MEM, `F3_LW)
      |=> s_out(OP_LW) ##0 out_base == {`CREG_HI,
          $past(in_instr[9:7])} && out_offset[1:0] == 2'h0
          && out_offset[6] == $past(in_instr[5]))
      else $error("word load misexpanded");

   AST_REG_QLOAD: assert property (
      s_take(`Q_MEM, `F3_FLD_LQ) ##0 (xlen == XL_128)
      |=> s_out(OP_LQ) ##0 out_offset[8] == $past(in_instr[10])
          && out_instr[6:0] == `OPC_MISCMEM)
      else $error("qword load misexpanded");

   AST_ILLEGAL: assert property (
      s_take(`Q_MEM, `F3_FSW_SD) ##0 (xlen == XL_32)
      ##0 !fp_single_en
      |=> out_valid && out_illegal && !out_match)
      else $error("missing float unit not flagged");

   AST_QUADRANT: assert property (
      in_fire && in_instr[1:0] != `Q_MEM
      && in_instr[1:0] != `Q_STK
      |=> out_valid && !out_match && !out_illegal)
      else $error("foreign quadrant claimed");

   AST_STORE_DATA: assert property (
      s_take(`Q_MEM, `F3_SW)
      |=> s_out(OP_SW) ##0 out_instr[24:20] == out_data
          && out_data == {`CREG_HI, $past(in_instr[4:2])})
      else $error("word store source misplaced");

   AST_HOLD: assert property (
      out_valid && !out_ready
      |=> out_valid && $stable(out_instr) [*1] ##1 1'b1)
      else $error("result dropped under stall");
endmodule // cls_expander
`default_nettype wire

// file: core/cls_field_decode.sv
// Purpose: register mapping and offset gather
// Assumes: selectors valid in the same cycle
// Notes:   combinational; the caller registers results
`timescale 1ns/100ps
`default_nettype none
`include "cls_defs.svh"
module cls_field_decode
   import cls_pkg::*;
(
   cls_field_if.dec f
);
   // ==========================================
   // register field mapping
   // ==========================================
   // 000..111 -> 8..15, same for int and float
   function automatic logic [4:0] creg(input logic [2:0] c);
      creg = {`CREG_HI, c};
   endfunction

   // base: sp for stack forms, else rs1' field
   always_comb begin
      if (f.is_css) begin
         f.base_reg = `REG_SP;
         f.data_reg = f.instr[6:2];         // full rs2
      end else begin
         f.base_reg = creg(f.instr[9:7]);
         f.data_reg = creg(f.instr[4:2]);
      end
   end

   // ==========================================
   // offset gather, low bits forced to zero
   // ==========================================
   // scaling is implied by the zero fill, no shifter
   always_comb begin
      case ({f.is_css, f.scale})
         {1'b1, SC_W}:
            f.offset = {4'h0, f.instr[8:7],
                        f.instr[12:9], 2'h0};
         {1'b1, SC_D}:
            f.offset = {3'h0, f.instr[9:7],
                        f.instr[12:10], 3'h0};
         {1'b1, SC_Q}:
            f.offset = {2'h0, f.instr[10:7],
                        f.instr[12:11], 4'h0};
         {1'b0, SC_W}:
            f.offset = {5'h00, f.instr[5], f.instr[12:10],
                        f.instr[6], 2'h0};
         {1'b0, SC_D}:
            f.offset = {4'h0, f.instr[6:5],
                        f.instr[12:10], 3'h0};
         {1'b0, SC_Q}:
            f.offset = {3'h0, f.instr[10], f.instr[6:5],
                        f.instr[12:11], 4'h0};
         default:
            f.offset = 12'h000;
      endcase
   end
endmodule // cls_field_decode
`default_nettype wire

// file: core/cls_field_if.sv
// Purpose: field-extraction link inside the expander
// Assumes: single clock, purely combinational signals
// Notes:   ctl drives the selectors, dec answers
`timescale 1ns/100ps
`default_nettype none
interface cls_field_if;
   import cls_pkg::*;
   logic [15:0] instr;    // compressed word
   logic        is_css;   // stack-relative layout
   scale_t      scale;    // access scale
   logic [4:0]  base_reg; // expanded base register
   logic [4:0]  data_reg; // expanded data register
   logic [11:0] offset;   // scaled byte offset
   modport dec (input instr, is_css, scale,
                output base_reg, data_reg, offset);
   modport ctl (output instr, is_css, scale,
                input base_reg, data_reg, offset);
endinterface // cls_field_if
`default_nettype wire

// file: core/cls_pkg.sv
// Purpose: shared types of the compressed load/store expander
// Assumes: constants live in cls_defs.svh
// Notes:   enums carry no codes
`default_nettype none
package cls_pkg;
   // base integer width of the core
   typedef enum logic [1:0] {XL_32, XL_64, XL_128} xlen_t;
   // access scale: x4, x8, x16
   typedef enum logic [1:0] {SC_W, SC_D, SC_Q} scale_t;
   // expanded operation
   typedef enum logic [3:0] {
      OP_NONE, OP_LW, OP_LD, OP_LQ, OP_FLW, OP_FLD,
      OP_SW, OP_SD, OP_SQ, OP_FSW, OP_FSD
   } op_t;
endpackage
`default_nettype wire

// file: verification/cls_exec_model.sv
// Purpose: execute-side model that takes expanded results
// Assumes: results offered on out_valid, taken on rising ref_clk
// Notes:   after each take it stays busy for stall_len waiting cycles
`timescale 1ns/100ps
`default_nettype none
module cls_exec_model (
   input  wire logic       ref_clk,   // core clock
   input  wire logic       rst,       // async, high
   input  wire logic       out_valid, // result offered
   input  wire logic [3:0] stall_len, // busy cycles per take
   output logic            out_ready  // accepts result
);
   // ==========================================
   // busy counter
   // ==========================================
   logic [3:0] wait_q; // busy cycles left
   // reload on each take; count only while a result waits, so a
   // slow pipe really holds the expander back
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wait_q <= 4'h0;
      end else if (out_valid && out_ready) begin
         wait_q <= stall_len;
      end else if (out_valid && (wait_q != 4'h0)) begin
         wait_q <= wait_q - 4'h1;
      end
   end
   // ready moves just after the edge, never on it
   assign #1 out_ready = (wait_q == 4'h0);
endmodule // cls_exec_model
`default_nettype wire

// file: verification/tb_compressed_load_store_expander.sv
// Purpose: self-checking bench of the compressed load/store expander
// Assumes: fetch driven here, execute side by cls_exec_model
// Notes:   every taken result is compared against a local reference
`timescale 1ns/100ps
`default_nettype none
`include "cls_defs.svh"
module tb_compressed_load_store_expander
   import cls_pkg::*;
;
   logic        ref_clk, rst, fp_single_en, fp_double_en;
   logic        in_valid, in_ready, out_valid, out_ready;
   logic        out_match, out_illegal;
   xlen_t       xlen;           // base width
   op_t         out_op;         // decoded operation
   logic [15:0] in_instr;       // compressed word
   logic [31:0] out_instr;      // expanded word
   logic [4:0]  out_base, out_data;
   logic [11:0] out_offset;
   logic [3:0]  stall_len;      // execute busy cycles
   logic [59:0] exp_q[$];       // results still owed
   int          n_errors, cmp_count;
   cls_expander cls_expander_i (.ref_clk(ref_clk), .rst(rst), .xlen(xlen),
      .fp_single_en(fp_single_en), .fp_double_en(fp_double_en),
      .in_valid(in_valid), .in_ready(in_ready), .in_instr(in_instr),
      .out_valid(out_valid), .out_ready(out_ready),
      .out_instr(out_instr), .out_match(out_match),
      .out_illegal(out_illegal), .out_op(out_op), .out_base(out_base),
      .out_data(out_data), .out_offset(out_offset));
   cls_exec_model cls_exec_model_i (.ref_clk(ref_clk), .rst(rst),
      .out_valid(out_valid), .stall_len(stall_len), .out_ready(out_ready));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // ==========================================
   // reference expansion, packed as the result fields
   // ==========================================
   function automatic logic [59:0] expect_of(input logic [15:0] c,
         input xlen_t x, input logic f, input logic d);
      op_t         op;
      logic        ill, css;
      logic [11:0] off;
      logic [4:0]  b, r;
      logic [6:0]  opc;
      logic [2:0]  w3;
      op = OP_NONE;
      css = (c[1:0] == `Q_STK);
      // stack quadrant only owns the F3_FSD_SQ and F3_FSW_SD store slots here
      if (c[1:0] == `Q_MEM || (css && c[15] && c[13])) begin
         case (c[15:13])
            3'h2: op = OP_LW;
            3'h6: op = OP_SW;
            3'h1: op = (x == XL_128) ? OP_LQ : (d ? OP_FLD : OP_NONE);
            3'h3: op = (x != XL_32) ? OP_LD : (f ? OP_FLW : OP_NONE);
            3'h5: op = (x == XL_128) ? OP_SQ : (d ? OP_FSD : OP_NONE);
            3'h7: op = (x != XL_32) ? OP_SD : (f ? OP_FSW : OP_NONE);
            default: op = OP_NONE;
         endcase
      end
      // stack-quadrant load slots are out of scope, never illegal
      ill = (op == OP_NONE) && c[13] && (c[1:0] == `Q_MEM || (css && c[15]));
      case (op)
         OP_LW, OP_SW, OP_FLW, OP_FSW, OP_LQ: w3 = `W3_WORD;
         OP_SQ: w3 = `W3_QWORD;
         default: w3 = `W3_DWORD;
      endcase
      if (op inside {OP_LQ, OP_SQ})
         off = css ? {2'h0, c[10:7], c[12:11], 4'h0}
                   : {3'h0, c[10], c[6:5], c[12:11], 4'h0};
      else if (w3 == `W3_DWORD)
         off = css ? {3'h0, c[9:7], c[12:10], 3'h0}
                   : {4'h0, c[6:5], c[12:10], 3'h0};
      else
         off = css ? {4'h0, c[8:7], c[12:9], 2'h0}
                   : {5'h0, c[5], c[12:10], c[6], 2'h0};
      case (op)
         OP_LW, OP_LD: opc = `OPC_LOAD;
         OP_LQ: opc = `OPC_MISCMEM;
         OP_FLW, OP_FLD: opc = `OPC_LOADFP;
         OP_FSW, OP_FSD: opc = `OPC_STOREFP;
         default: opc = `OPC_STORE;
      endcase
      b = css ? `REG_SP : {`CREG_HI, c[9:7]};
      r = css ? c[6:2] : {`CREG_HI, c[4:2]};
      if (op == OP_NONE)
         return {1'b0, ill, OP_NONE, 22'h0, `INSTR_ZERO};
      if (op inside {OP_LW, OP_LD, OP_LQ, OP_FLW, OP_FLD})
         return {2'h2, op, b, r, off, off, b, w3, r, opc};
      return {2'h2, op, b, r, off, off[11:5], r, b, w3, off[4:0], opc};
   endfunction
   // ==========================================
   // comparison and run control
   // ==========================================
   task automatic check(input logic [59:0] seen, input logic [59:0] want);
      cmp_count++;
      if (seen !== want) begin
         n_errors++;
         $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
      end
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic hang(input string what);
      n_errors++;
      $display("MISMATCH t=%0t %s", $time, what);
      complete_run();
   endtask
   // judge each result in the half cycle before the edge that takes it;
   // junk register fields of unmatched words are masked off
   always @(negedge ref_clk) begin : take_chk
      logic [59:0] s, e;
      if (!rst && out_valid && out_ready) begin
         e = (exp_q.size() != 0) ? exp_q.pop_front() : 60'h0;
         s = {out_match, out_illegal, out_op, out_base, out_data,
              out_offset, out_instr};
         if (!e[59]) s[53:32] = 22'h0;
         check(s[31:0], e[31:0]);
         check(s[57:54], e[57:54]);
         check(s[59:58], e[59:58]);
         check(s[53:44], e[53:44]);
         check(s[43:32], e[43:32]);
      end
   end
   // ==========================================
   // fetch-side driver, called just after an edge
   // ==========================================
   task automatic send(input logic [15:0] c);
      logic r;
      int   n;
      in_valid = 1'b1;
      in_instr = c;
      r = 1'b0;
      for (n = 0; n < 50 && !r; n++) begin
         @(negedge ref_clk);
         r = in_ready;
         @(posedge ref_clk);
      end
      if (!r) hang("no handshake");
      else exp_q.push_back(expect_of(c, xlen, fp_single_en, fp_double_en));
      #1;
   endtask
   task automatic drain();
      int n;
      in_valid = 1'b0;
      for (n = 0; n < 100 && exp_q.size() != 0; n++) @(posedge ref_clk);
      if (exp_q.size() != 0) hang("result missing");
      @(posedge ref_clk);
      #1;
   endtask
   // ==========================================
   // scenarios
   // ==========================================
   // every quadrant and slot, back to back, under six configurations
   task automatic test_sweep();
      xlen_t       cx[6] = '{XL_32, XL_32, XL_32, XL_64, XL_64, XL_128};
      logic [5:0]  cf = 6'h2D;
      logic [5:0]  cd = 6'h29;
      logic [10:0] pat[3] = '{11'h7FF, 11'h2B5, 11'h000};
      for (int i = 0; i < 6; i++) begin
         xlen = cx[i];
         fp_single_en = cf[i];
         fp_double_en = cd[i];
         for (int q = 0; q < 4; q++)
            for (int f3 = 0; f3 < 8; f3++)
               for (int p = 0; p < 3; p++)
                  send({f3[2:0], pat[p], q[1:0]});
         drain();
      end
      $display("test sweep done");
   endtask
   // one result one cycle after the take, gone when taken
   task automatic test_latency();
      send({3'h2, 11'h4E6, 2'h0});
      in_valid = 1'b0;
      @(negedge ref_clk);
      check(out_valid, 1'b1);
      @(negedge ref_clk);
      check(out_valid, 1'b0);
      drain();
      $display("test latency done");
   endtask
   // slow execute: result stands, next word waits its turn
   task automatic test_stall();
      logic [31:0] held;
      xlen = XL_128;
      stall_len = 4'h3;
      send({3'h2, 11'h4E6, 2'h0});
      send({3'h7, 11'h1C9, 2'h0});
      in_instr = {3'h5, 11'h3FF, 2'h2};
      @(negedge ref_clk);
      held = out_instr;
      check(in_ready, 1'b0);
      repeat (2) @(negedge ref_clk);
      check(out_instr, held);
      @(posedge ref_clk);
      #1;
      send({3'h5, 11'h3FF, 2'h2});
      stall_len = 4'h0;
      drain();
      $display("test stall done");
   endtask
   // reset with a result pending, then recover
   task automatic test_reset();
      stall_len = 4'h8;
      send({3'h1, 11'h155, 2'h0});
      in_valid = 1'b0;
      rst = 1'b1;
      @(negedge ref_clk);
      check({out_valid, out_match, out_illegal, out_instr}, 35'h0);
      check({out_op, in_ready}, {OP_NONE, 1'b1});
      @(posedge ref_clk);
      #1;
      exp_q.delete();
      rst = 1'b0;
      stall_len = 4'h0;
      send({3'h6, 11'h2AA, 2'h0});
      drain();
      $display("test reset done");
   endtask
   initial begin
      rst = 1'b1;
      in_valid = 1'b0;
      in_instr = 16'h0000;
      xlen = XL_32;
      fp_single_en = 1'b0;
      fp_double_en = 1'b0;
      stall_len = 4'h0;
      n_errors = 0;
      cmp_count = 0;
      repeat (6) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      test_sweep();
      test_latency();
      test_stall();
      test_reset();
      complete_run();
   end
endmodule // tb_compressed_load_store_expander
`default_nettype wire
